/* hex_record_loader.sv */
// Hex record loader: parses ASCII load records and writes data bytes to memory.
`timescale 1ns/10ps
`include "hex_record_loader_params.svh"
module hex_record_loader #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] char_i,
    input wire logic char_valid_i,
    output logic char_ready_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_data_o,
    output logic mem_wr_o,
    input wire logic mem_ready_i,
    output logic loading_o,
    output logic done_o,
    output logic [15:0] entry_addr_o,
    output logic sum_err_o,
    output logic fmt_err_o,
    output logic [15:0] rec_count_o
);
    hex_record_loader_pkg::parse_state_e state;
    logic [3:0] nib;
    logic nib_ok;
    logic hi_half;
    logic [3:0] hi_nib;
    logic [3:0] kind;
    logic [7:0] remain;
    logic [7:0] field_idx;
    logic [7:0] sum;
    logic [15:0] addr;
    logic [15:0] wr_addr;
    logic seen_data;
    logic rec_bad;
    logic [7:0] byte_val;
    logic byte_done;
    logic take;
    logic kind_take;
    logic pair_take;
    logic bad_char;
    logic last_pair;
    logic drop;
    logic rec_good;
    logic stage_valid;
    logic stage_ready;
    logic [23:0] fifo_out;
    logic fifo_valid;
    logic fifo_ready;
    logic wr_busy;

    hex_nibble u_nibble (
        .char_i(char_i),
        .nibble_o(nib),
        .valid_o(nib_ok)
    );

    // Record data is staged in the FIFO and only released after the checksum passes.
    byte_fifo #(
        .WIDTH(24),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .clear_i(drop),
        .in_data_i({wr_addr, byte_val}),
        .in_valid_i(stage_valid),
        .in_ready_o(stage_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_ready)
    );

    assign byte_val = {hi_nib, nib};
    assign byte_done = (state == hex_record_loader_pkg::ST_FIELD) && !hi_half && nib_ok;
    // A data byte of an S1 record waits for FIFO room; records longer than the FIFO stall input.
    assign stage_valid = byte_done && kind == `KIND_DATA && field_idx > `ADDR_BYTES_16 &&
                         remain > 8'h01 && char_valid_i;
    assign char_ready_o = (state == hex_record_loader_pkg::ST_HUNT) ||
                          (state == hex_record_loader_pkg::ST_KIND) ||
                          (state == hex_record_loader_pkg::ST_FIELD &&
                           (!stage_valid || stage_ready));
    assign take = char_valid_i && char_ready_o;
    assign kind_take = (state == hex_record_loader_pkg::ST_KIND) && take;
    assign pair_take = byte_done && take;
    assign bad_char = (state == hex_record_loader_pkg::ST_FIELD) && take && !nib_ok;
    assign last_pair = pair_take && (field_idx != 8'h00) && (remain == 8'h01);
    assign rec_good = (state == hex_record_loader_pkg::ST_CHECK) && !rec_bad;
    // A failed or aborted record leaves nothing staged in the FIFO.
    assign drop = bad_char || (state == hex_record_loader_pkg::ST_CHECK && rec_bad);
    assign loading_o = seen_data && (state != hex_record_loader_pkg::ST_DONE);
    assign done_o = (state == hex_record_loader_pkg::ST_DONE);
    assign fifo_ready = fifo_valid && (state == hex_record_loader_pkg::ST_WRITE) &&
                        (!wr_busy || mem_ready_i);

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state <= hex_record_loader_pkg::ST_HUNT;
        end else begin
            case (state)
                hex_record_loader_pkg::ST_HUNT: begin
                    // Anything before an S, line numbers and line ends included, is skipped.
                    if (take && char_i == `CH_S) begin
                        state <= hex_record_loader_pkg::ST_KIND;
                    end
                end
                hex_record_loader_pkg::ST_KIND: begin
                    // A second S restarts the type field, so the state simply stays.
                    if (take && char_i != `CH_S) begin
                        if (nib_ok && (nib == `KIND_HEADER ||
                                       nib == `KIND_DATA || nib == `KIND_END)) begin
                            state <= hex_record_loader_pkg::ST_FIELD;
                        end else begin
                            state <= hex_record_loader_pkg::ST_HUNT;
                        end
                    end
                end
                hex_record_loader_pkg::ST_FIELD: begin
                    if (bad_char) begin
                        state <= hex_record_loader_pkg::ST_HUNT;
                    end else if (last_pair) begin
                        state <= hex_record_loader_pkg::ST_CHECK;
                    end
                end
                hex_record_loader_pkg::ST_CHECK: begin
                    // An end record before the first data record is discarded like any other.
                    if (rec_bad) begin
                        state <= hex_record_loader_pkg::ST_HUNT;
                    end else if (kind == `KIND_END && seen_data) begin
                        state <= hex_record_loader_pkg::ST_WRITE;
                    end else if (kind == `KIND_DATA) begin
                        state <= hex_record_loader_pkg::ST_WRITE;
                    end else begin
                        state <= hex_record_loader_pkg::ST_HUNT;
                    end
                end
                hex_record_loader_pkg::ST_WRITE: begin
                    if (!fifo_valid && (!wr_busy || mem_ready_i)) begin
                        state <= (kind == `KIND_END) ? hex_record_loader_pkg::ST_DONE :
                                 hex_record_loader_pkg::ST_HUNT;
                    end
                end
                hex_record_loader_pkg::ST_DONE: begin
                    state <= hex_record_loader_pkg::ST_DONE;
                end
                default: begin
                    state <= hex_record_loader_pkg::ST_HUNT;
                end
            endcase
        end
    end

    // Two characters make a byte, the first giving the upper nibble.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            hi_half <= 1'b1;
            hi_nib <= 4'h0;
        end else if (kind_take) begin
            hi_half <= 1'b1;
        end else if (state == hex_record_loader_pkg::ST_FIELD && take && nib_ok) begin
            hi_half <= !hi_half;
            if (hi_half) begin
                hi_nib <= nib;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            kind <= 4'h0;
        end else if (kind_take) begin
            kind <= nib;
        end
    end

    // The length byte loads the count of pairs still to come; the checksum pair is the last.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            field_idx <= 8'h00;
            remain <= 8'h00;
        end else if (kind_take) begin
            field_idx <= 8'h00;
        end else if (pair_take) begin
            field_idx <= field_idx + 8'h01;
            if (field_idx == 8'h00) begin
                remain <= byte_val;
            end else begin
                remain <= remain - 8'h01;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum <= 8'h00;
        end else if (kind_take) begin
            sum <= 8'h00;
        end else if (pair_take && !last_pair) begin
            sum <= (field_idx == 8'h00) ? byte_val : sum + byte_val;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr <= `ADDR_RESET;
            wr_addr <= `ADDR_RESET;
        end else if (pair_take) begin
            if (field_idx == 8'h01) begin
                addr[15:8] <= byte_val;
            end else if (field_idx == `ADDR_BYTES_16) begin
                addr[7:0] <= byte_val;
                wr_addr <= {addr[15:8], byte_val};
            end else if (stage_valid) begin
                wr_addr <= wr_addr + 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rec_bad <= 1'b0;
        end else if (kind_take) begin
            rec_bad <= 1'b0;
        end else if (pair_take && field_idx == 8'h00) begin
            // Too short to hold address and checksum.
            if (byte_val < `ADDR_BYTES_16 + 8'h01) begin
                rec_bad <= 1'b1;
            end
        end else if (last_pair && byte_val != ~sum) begin
            rec_bad <= 1'b1;
        end
    end

    // Header records before the first data record never count as the start of loading.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seen_data <= 1'b0;
        end else if (rec_good && kind == `KIND_DATA) begin
            seen_data <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rec_count_o <= 16'h0000;
        end else if (rec_good && kind == `KIND_DATA) begin
            rec_count_o <= rec_count_o + 16'h0001;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            entry_addr_o <= `ADDR_RESET;
        end else if (rec_good && kind == `KIND_END && seen_data) begin
            entry_addr_o <= addr;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sum_err_o <= 1'b0;
        end else if (state == hex_record_loader_pkg::ST_CHECK && rec_bad) begin
            sum_err_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fmt_err_o <= 1'b0;
        end else if (state == hex_record_loader_pkg::ST_FIELD && take && !nib_ok) begin
            fmt_err_o <= 1'b1;
        end
    end

    // One byte is presented per strobe; the next waits for the memory ready.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_wr_o <= 1'b0;
        end else begin
            mem_wr_o <= fifo_ready;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_addr_o <= 16'h0000;
            mem_data_o <= 8'h00;
        end else if (fifo_ready) begin
            mem_addr_o <= fifo_out[23:8];
            mem_data_o <= fifo_out[7:0];
        end
    end

    // A strobe stays outstanding until the memory answers it.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_busy <= 1'b0;
        end else if (fifo_ready) begin
            wr_busy <= 1'b1;
        end else if (mem_ready_i) begin
            wr_busy <= 1'b0;
        end
    end
endmodule

/* hex_record_loader_params.svh */
// Constants of the hex record loader: character codes, record layout and reset values.
// Function
// - First character high nibble, second low nibble.
// - Record starts with S and kind digit.
// - Length counts address, data and checksum bytes.
// - Address is two, three or four bytes; the code takes two-byte addresses only.
// - Accept any data byte count; the code stalls for good on more than FIFO_DEPTH data bytes.
// - Checksum is complement of byte sum.
// - CR, LF and NUL end records silently; the code ends records on length, and one inside a record sets fmt_err_o.
// - Skip leading field before the type.
// - Only S1 and S9; ignore before S1.
// - S1 data goes to consecutive addresses.
// - S9 entry address captured and reported.
// - S0 header checked but never stored.
// - Several header records are accepted.
// - Length and checksum checked on every record.
// - ASCII digits and A-F map to nibbles.
`ifndef HEX_RECORD_LOADER_PARAMS_SVH
`define HEX_RECORD_LOADER_PARAMS_SVH
`define CH_S 8'h53
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define CH_NUL 8'h00
`define CH_0 8'h30
`define CH_9 8'h39
`define CH_UA 8'h41
`define CH_UF 8'h46
`define CH_LA 8'h61
`define CH_LF_LOWER 8'h66
`define KIND_HEADER 4'h0
`define KIND_DATA 4'h1
`define KIND_END 4'h9
`define ADDR_BYTES_16 8'h02
`define ADDR_RESET 16'h0000
`define FIFO_DEPTH_DEF 16
`endif

/* hex_record_loader_pkg.sv */
// Types shared by the hex record loader files.
package hex_record_loader_pkg;
    typedef enum logic [2:0] {
        ST_HUNT,
        ST_KIND,
        ST_FIELD,
        ST_CHECK,
        ST_WRITE,
        ST_DONE
    } parse_state_e;
    typedef logic [7:0] byte_t;
endpackage

/* hex_nibble.sv */
// Decoder of one ASCII hexadecimal character to a nibble.
`timescale 1ns/10ps
`include "hex_record_loader_params.svh"
module hex_nibble (
    input wire logic [7:0] char_i,
    output logic [3:0] nibble_o,
    output logic valid_o
);
    always_comb begin
        nibble_o = 4'h0;
        valid_o = 1'b1;
        if (char_i >= `CH_0 && char_i <= `CH_9) begin
            nibble_o = char_i[3:0];
        end else if ((char_i >= `CH_UA && char_i <= `CH_UF) ||
                     (char_i >= `CH_LA && char_i <= `CH_LF_LOWER)) begin
            nibble_o = char_i[3:0] + 4'h9;
        end else begin
            valid_o = 1'b0;
        end
    end
endmodule

/* byte_fifo.sv */
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic clear_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (clear_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* hex_record_loader_asserts.sv */
// Concurrent checks on the ports of the hex record loader.
`timescale 1ns/10ps
module hex_record_loader_asserts (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic char_ready_o,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_data_o,
    input wire logic mem_wr_o,
    input wire logic mem_ready_i,
    input wire logic loading_o,
    input wire logic done_o,
    input wire logic [15:0] entry_addr_o,
    input wire logic sum_err_o,
    input wire logic fmt_err_o,
    input wire logic [15:0] rec_count_o
);
    logic pend;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // A strobe stays owed until the memory has answered it.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend <= 1'b0;
        end else if (mem_wr_o) begin
            pend <= 1'b1;
        end else if (mem_ready_i) begin
            pend <= 1'b0;
        end
    end
    AST_WR_PULSE: assert property (mem_wr_o |=> !mem_wr_o)
        else $error("write strobe longer than one cycle");
    AST_WR_WAIT: assert property (mem_wr_o |-> !pend)
        else $error("write strobe before memory ready");
    AST_WR_HOLD: assert property (!mem_wr_o |-> $stable(mem_addr_o) && $stable(mem_data_o))
        else $error("write address or data moved without strobe");
    AST_WR_LOADING: assert property (mem_wr_o |-> loading_o)
        else $error("write outside a load");
    AST_SUM_STICKY: assert property (sum_err_o |=> sum_err_o)
        else $error("sum error flag cleared");
    AST_FMT_STICKY: assert property (fmt_err_o |=> fmt_err_o)
        else $error("format error flag cleared");
    AST_DONE_REFUSE: assert property (done_o |-> !char_ready_o && !loading_o)
        else $error("characters taken after end record");
    AST_ENTRY_HOLD: assert property (done_o |=> done_o && $stable(entry_addr_o))
        else $error("entry address or done changed after end");
    AST_COUNT_STEP: assert property (rec_count_o != $past(rec_count_o) |->
        rec_count_o == $past(rec_count_o) + 16'h0001)
        else $error("record count jumped");
endmodule
bind hex_record_loader hex_record_loader_asserts chk_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .char_ready_o(char_ready_o), .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o),
    .mem_wr_o(mem_wr_o), .mem_ready_i(mem_ready_i), .loading_o(loading_o), .done_o(done_o),
    .entry_addr_o(entry_addr_o), .sum_err_o(sum_err_o), .fmt_err_o(fmt_err_o),
    .rec_count_o(rec_count_o));

/* host_model.sv */
// Host model that sends an ASCII record stream over a valid and ready handshake.
`timescale 1ns/10ps
module host_model (
    input wire logic mclk_i,
    input wire logic char_ready_o,
    output logic [7:0] char_i,
    output logic char_valid_i,
    output logic stuck_o
);
    initial begin
        char_i = 8'h00;
        char_valid_i = 1'b0;
        stuck_o = 1'b0;
    end
    // Each character is held until the loader takes it; a released line shows the inverse.
    // With nul set, a NUL line end follows the string, which cannot itself hold one.
    task automatic send(input string s, input bit nul = 1'b0);
        int k;
        for (int i = 0; i < s.len() + int'(nul); i++) begin
            char_i <= (i < s.len()) ? s[i] : 8'h00;
            char_valid_i <= 1'b1;
            k = 0;
            do begin
                @(posedge mclk_i);
                k++;
            end while (char_ready_o !== 1'b1 && k < 400);
            if (k >= 400) begin
                stuck_o = 1'b1;
                break;
            end
        end
        char_valid_i <= 1'b0;
        char_i <= ~char_i;
        @(posedge mclk_i);
    endtask
endmodule

/* hex_record_loader_tb_top.sv */
// Self-checking testbench of the hex record loader.
`timescale 1ns/10ps
module hex_record_loader_tb_top;
    logic mclk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic mem_ready_i = 1'b0;
    logic [7:0] char_i, mem_data_o;
    logic char_valid_i, char_ready_o, mem_wr_o, loading_o, done_o, sum_err_o, fmt_err_o, stuck;
    logic [15:0] mem_addr_o, entry_addr_o, rec_count_o;
    logic [23:0] wq[$];
    int miscompares = 0;
    int check_count = 0;
    int stall = 0;
    int wait_left = 0;
    always #2.5 mclk_i = ~mclk_i;
    host_model host_u (.mclk_i(mclk_i), .char_ready_o(char_ready_o), .char_i(char_i),
        .char_valid_i(char_valid_i), .stuck_o(stuck));
    hex_record_loader #(.FIFO_DEPTH(16)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .char_i(char_i), .char_valid_i(char_valid_i), .char_ready_o(char_ready_o),
        .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o), .mem_wr_o(mem_wr_o),
        .mem_ready_i(mem_ready_i), .loading_o(loading_o), .done_o(done_o),
        .entry_addr_o(entry_addr_o), .sum_err_o(sum_err_o), .fmt_err_o(fmt_err_o),
        .rec_count_o(rec_count_o));
    // Memory logs each strobe and answers it after a programmable stall.
    always @(posedge mclk_i) begin
        mem_ready_i <= 1'b0;
        if (mem_wr_o === 1'b1) begin
            wq.push_back({mem_addr_o, mem_data_o});
            wait_left <= stall + 1;
        end else if (wait_left == 1) begin
            mem_ready_i <= 1'b1;
            wait_left <= 0;
        end else if (wait_left > 1) begin
            wait_left <= wait_left - 1;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    function automatic string rec(input int kind, input logic [15:0] a, input logic [7:0] d[$],
        input bit bad, input bit lc);
        logic [7:0] sum;
        string s;
        sum = 8'(d.size() + 3) + a[15:8] + a[7:0];
        s = $sformatf("%02X%04X", 8'(d.size() + 3), a);
        foreach (d[i]) begin
            s = {s, $sformatf("%02X", d[i])};
            sum += d[i];
        end
        s = {s, $sformatf("%02X", (~sum) ^ {7'h00, bad})};
        if (lc) s = s.tolower();
        return {$sformatf("S%0d", kind), s, "\r\n"};
    endfunction
    task automatic settle(input int n);
        int k;
        k = 0;
        repeat (30) @(posedge mclk_i);
        while ((wq.size() < n || mem_wr_o !== 1'b0 || wait_left != 0) && k < 500) begin
            @(posedge mclk_i);
            k++;
        end
        if (k >= 500 || stuck === 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask
    task automatic chk_writes(input logic [15:0] a, input logic [7:0] d[$]);
        check(wq.size(), d.size());
        foreach (d[i]) begin
            if (i < wq.size()) check(wq[i], {a + 16'(i), d[i]});
        end
        wq.delete();
    endtask
    task automatic t_lead();
        host_u.send("0010 xyz\r\n");
        host_u.send({"0020 ", rec(0, 16'h0000, '{8'h48, 8'h44, 8'h52}, 0, 0)});
        host_u.send(rec(0, 16'h0000, '{8'h41}, 0, 0), 1'b1);
        host_u.send(rec(9, 16'h0000, '{}, 0, 0));
        settle(0);
        check(done_o, 0);
        check(loading_o, 0);
        check(wq.size(), 0);
        host_u.send({"0030 ", rec(1, 16'h1234, '{8'h5a, 8'ha5, 8'h0f}, 0, 0)});
        settle(3);
        chk_writes(16'h1234, '{8'h5a, 8'ha5, 8'h0f});
        check({loading_o, sum_err_o, fmt_err_o, rec_count_o}, 19'h40001);
    endtask
    task automatic t_bad();
        logic [7:0] d[$];
        host_u.send("S1020002FB\r\n");
        settle(0);
        check(sum_err_o, 1);
        host_u.send(rec(1, 16'h2000, '{8'h01, 8'h02, 8'h03}, 1, 0));
        settle(0);
        chk_writes(16'h2000, '{});
        check(rec_count_o, 1);
        for (int i = 0; i < 16; i++) d.push_back(8'(i * 17));
        stall = 3;
        host_u.send(rec(1, 16'hfff0, d, 0, 1));
        settle(16);
        chk_writes(16'hfff0, d);
        check(rec_count_o, 2);
        stall = 0;
    endtask
    task automatic t_fmt();
        host_u.send("S1050100AB4G77\r\n");
        host_u.send(rec(1, 16'h0300, '{}, 0, 0));
        settle(0);
        check(fmt_err_o, 1);
        chk_writes(16'h0100, '{});
        check(rec_count_o, 3);
    endtask
    task automatic t_end();
        host_u.send("S903ABCD84");
        settle(0);
        check({done_o, loading_o, char_ready_o}, 3'h4);
        check(entry_addr_o, 16'habcd);
        check(rec_count_o, 3);
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        check({done_o, rec_count_o, char_ready_o}, 18'h00001);
        rst_b_i <= 1'b1;
        @(posedge mclk_i);
        t_lead();
        t_bad();
        t_fmt();
        t_end();
        check(stuck, 0);
        summarize();
    end
endmodule
